// ---- hdl/ebm_pin_mux.sv ----
`timescale 1ns/1ps
// Contract
// - address-high control bit 1 in bus mode: that upper pin is a plain port, or on the top four pins its pulse output when that channel is enabled
// - address-high control bit 0: upper address bit driven, muxed or non-muxed
// - non-multiplexed bus mode: port 3 and 4 pins carry address bits 0 to 15
// - bus mode: address latch enable driven on its pin, otherwise plain port
// - bus mode: read strobe driven on its pin, otherwise plain port
// - lower write strobe driven in bus mode; plain port when strobe enable is 0
// - upper write strobe only in 16-bit bus mode and with strobe enable set
// - bus mode with hold enable: hold request input taken, otherwise plain port
// - bus mode with hold enable: hold acknowledge driven, otherwise plain port
// - bus mode with ready enable: ready input sampled, otherwise plain port
// - bus mode with clock enable: machine cycle clock driven, else plain port
// - pulse generator channels 0 to 3 share the top four upper address pins
// - p9.6 feeds converter trigger and free-run clock, each when active
module ebm_pin_mux (
	// clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_rst,
	// register port
	input  wire logic [ebm_pkg::ADDR_W-1:0]   i_addr,
	input  wire logic [ebm_pkg::DATA_W-1:0]   i_wdata,
	input  wire logic                         i_wr_en,
	input  wire logic                         i_rd_en,
	output logic      [ebm_pkg::DATA_W-1:0]   o_rdata,
	// bus mode, from the mode logic
	input  wire logic                         i_ext_bus,
	input  wire logic                         i_nonmux,
	input  wire logic                         i_bus_16bit,
	// bus engine side
	input  wire logic [23:0]                  i_bus_addr,
	input  wire logic                         i_ale,
	input  wire logic                         i_rd_strobe_n,
	input  wire logic                         i_write_strobe_low_n,
	input  wire logic                         i_write_strobe_high_n,
	input  wire logic                         i_hold_ack_out,
	input  wire logic                         i_cycle_clk,
	output logic                              o_hold_request_in,
	output logic                              o_ready,
	// peripherals
	input  wire logic [ebm_pkg::NPGEN-1:0]    i_pulse_gen_out_0_3,
	input  wire logic                         i_adc_active,
	input  wire logic                         i_freerun_active,
	output logic                              o_converter_trigger_in,
	output logic                              o_freerun_clock_in,
	// shared pins
	input  wire logic [ebm_pkg::NPIN-1:0]     i_pin,
	output logic      [ebm_pkg::NPIN-1:0]     o_pin,
	output logic      [ebm_pkg::NPIN-1:0]     o_pin_oe
);
	import ebm_pkg::*;

	ebm_state_t st;
	ebm_state_t next_st;

	logic [NPIN-1:0] func_sel;
	logic [NPIN-1:0] func_out;
	logic [NPIN-1:0] func_oe;
	logic [NPIN-1:0] cell_out;
	logic [NPIN-1:0] cell_oe;
	logic            wstb_en;
	logic            hold_en;
	logic            rdy_en;
	logic            cke;

	assign wstb_en = st.bus_pin_ctrl_reg[CTRL_WSTB_BIT];
	assign hold_en = st.bus_pin_ctrl_reg[CTRL_HOLD_BIT];
	assign rdy_en  = st.bus_pin_ctrl_reg[CTRL_RDY_BIT];
	assign cke = st.bus_pin_ctrl_reg[CTRL_CKE_BIT];

	// function ownership of each pin
	always_comb begin
		func_sel = '0;
		func_out = '0;
		func_oe  = '0;
		for (int i = 0; i < 8; i++) begin
			if (i_ext_bus && !st.addr_high_output_ctrl[i]) begin
				func_sel[i] = 1'b1;
				func_out[i] = i_bus_addr[16+i];
				func_oe[i]  = 1'b1;
			end else if (i >= PGEN_FIRST && st.pgen_en[i-PGEN_FIRST]) begin
				func_sel[i] = 1'b1;
				func_out[i] = i_pulse_gen_out_0_3[i-PGEN_FIRST];
				func_oe[i]  = 1'b1;
			end
		end
		for (int j = 0; j < 16; j++) begin
			func_sel[PIN_P3_BASE+j] = i_ext_bus && i_nonmux;
			func_out[PIN_P3_BASE+j] = i_bus_addr[j];
			func_oe[PIN_P3_BASE+j]  = 1'b1;
		end
		func_sel[PIN_ALE] = i_ext_bus;
		func_out[PIN_ALE] = i_ale;
		func_oe[PIN_ALE]  = 1'b1;
		func_sel[PIN_RD]  = i_ext_bus;
		func_out[PIN_RD]  = i_rd_strobe_n;
		func_oe[PIN_RD]   = 1'b1;
		func_sel[PIN_WSTB_LO] = i_ext_bus && wstb_en;
		func_out[PIN_WSTB_LO] = i_write_strobe_low_n;
		func_oe[PIN_WSTB_LO]  = 1'b1;
		func_sel[PIN_WSTB_HI] = i_ext_bus && i_bus_16bit && wstb_en;
		func_out[PIN_WSTB_HI] = i_write_strobe_high_n;
		func_oe[PIN_WSTB_HI]  = 1'b1;
		// hold request and ready are inputs: the function owns the pin undriven
		func_sel[PIN_HOLD_REQ] = i_ext_bus && hold_en;
		func_sel[PIN_HOLD_ACK] = i_ext_bus && hold_en;
		func_out[PIN_HOLD_ACK] = i_hold_ack_out;
		func_oe[PIN_HOLD_ACK]  = 1'b1;
		func_sel[PIN_RDY] = i_ext_bus && rdy_en;
		func_sel[PIN_CLK] = i_ext_bus && cke;
		func_out[PIN_CLK] = i_cycle_clk;
		func_oe[PIN_CLK]  = 1'b1;
		func_sel[PIN_P96] = i_adc_active || i_freerun_active;
	end

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_cell
			ebm_pin_cell u_cell (
				.i_func_sel  (func_sel[g]),
				.i_func_out  (func_out[g]),
				.i_func_oe   (func_oe[g]),
				.i_port_data (st.port_data[g]),
				.i_port_dir  (st.port_dir[g]),
				.o_pin_out   (cell_out[g]),
				.o_pin_oe    (cell_oe[g])
			);
		end
	endgenerate

	always_comb begin
		next_st = st;
		// pin inputs: two flops before anything reads them
		next_st.sync1   = i_pin;
		next_st.sync2   = st.sync1;
		// pins are registered so that no glitch from the mux reaches the board
		next_st.pin_out = cell_out;
		next_st.pin_oe  = cell_oe;
		if (i_wr_en) begin
			case (i_addr)
				OFS_P2_DATA:  next_st.port_data[7:0]   = i_wdata;
				OFS_P3_DATA:  next_st.port_data[15:8]  = i_wdata;
				OFS_P4_DATA:  next_st.port_data[23:16] = i_wdata;
				OFS_P5_DATA:  next_st.port_data[31:24] = i_wdata;
				OFS_P2_DIR:   next_st.port_dir[7:0]    = i_wdata;
				OFS_P3_DIR:   next_st.port_dir[15:8]   = i_wdata;
				OFS_P4_DIR:   next_st.port_dir[23:16]  = i_wdata;
				OFS_P5_DIR:   next_st.port_dir[31:24]  = i_wdata;
				OFS_P96: begin
					next_st.port_data[PIN_P96] = i_wdata[P96_DATA_BIT];
					next_st.port_dir[PIN_P96]  = i_wdata[P96_DIR_BIT];
				end
				OFS_ADDR_HI:  next_st.addr_high_output_ctrl = i_wdata;
				OFS_BUS_CTRL: next_st.bus_pin_ctrl_reg = i_wdata[CTRL_W-1:0];
				OFS_PGEN_EN:  next_st.pgen_en = i_wdata[NPGEN-1:0];
				default: ;
			endcase
		end
		// data offsets read the synchronised pin levels, as a port read would
		next_st.rdata = '0;
		if (i_rd_en) begin
			case (i_addr)
				OFS_P2_DATA:  next_st.rdata = st.sync2[7:0];
				OFS_P3_DATA:  next_st.rdata = st.sync2[15:8];
				OFS_P4_DATA:  next_st.rdata = st.sync2[23:16];
				OFS_P5_DATA:  next_st.rdata = st.sync2[31:24];
				OFS_P2_DIR:   next_st.rdata = st.port_dir[7:0];
				OFS_P3_DIR:   next_st.rdata = st.port_dir[15:8];
				OFS_P4_DIR:   next_st.rdata = st.port_dir[23:16];
				OFS_P5_DIR:   next_st.rdata = st.port_dir[31:24];
				OFS_P96: begin
					next_st.rdata[P96_DATA_BIT] = st.port_data[PIN_P96];
					next_st.rdata[P96_DIR_BIT]  = st.port_dir[PIN_P96];
					next_st.rdata[P96_PIN_BIT]  = st.sync2[PIN_P96];
				end
				OFS_ADDR_HI:  next_st.rdata = st.addr_high_output_ctrl;
				OFS_BUS_CTRL: next_st.rdata[CTRL_W-1:0] = st.bus_pin_ctrl_reg;
				OFS_PGEN_EN:  next_st.rdata[NPGEN-1:0] = st.pgen_en;
				default:      next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st.port_data             <= RST_PORT_DATA;
			st.port_dir              <= RST_PORT_DIR;
			st.addr_high_output_ctrl <= RST_ADDR_HI;
			st.bus_pin_ctrl_reg      <= RST_BUS_CTRL;
			st.pgen_en               <= RST_PGEN_EN;
			st.sync1                 <= '0;
			st.sync2                 <= '0;
			st.pin_out               <= '0;
			st.pin_oe                <= '0;
			st.rdata                 <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_pin    = st.pin_out;
	assign o_pin_oe = st.pin_oe;
	// without the ready function the bus never waits
	assign o_hold_request_in      = i_ext_bus && hold_en && st.sync2[PIN_HOLD_REQ];
	assign o_ready                = (i_ext_bus && rdy_en) ? st.sync2[PIN_RDY] : 1'b1;
	// the two-wire pins are not muxed here; software must keep them released
	assign o_converter_trigger_in = i_adc_active && st.sync2[PIN_P96];
	assign o_freerun_clock_in     = i_freerun_active && st.sync2[PIN_P96];

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_hold_on;
		(i_ext_bus && hold_en)[*3];
	endsequence

	sequence s_bus_left;
		$past(i_ext_bus) && !i_ext_bus;
	endsequence

	a_addr_high_port: assert property (i_ext_bus && st.addr_high_output_ctrl[1]
		|=> o_pin_oe[1] == $past(st.port_dir[1]) && o_pin[1] == $past(st.port_data[1]))
		else $error("upper address pin not returned to port");
	a_addr_high_drive: assert property (i_ext_bus && !st.addr_high_output_ctrl[3]
		|=> o_pin_oe[3] && o_pin[3] == $past(i_bus_addr[19]))
		else $error("upper address bit not driven");
	a_low_addr_drive: assert property (i_ext_bus && i_nonmux
		|=> (&o_pin_oe[23:8]) && o_pin[23:8] == $past(i_bus_addr[15:0]))
		else $error("low address lines not driven");
	a_ale_pin: assert property (i_ext_bus |=> o_pin_oe[PIN_ALE] && o_pin[PIN_ALE] == $past(i_ale))
		else $error("latch enable not on its pin");
	a_read_strobe: assert property (!i_ext_bus |=> o_pin_oe[PIN_RD] == $past(st.port_dir[PIN_RD]))
		else $error("read strobe pin not a port outside bus mode");
	a_wstb_lo_gate: assert property (i_ext_bus && !wstb_en
		|=> o_pin_oe[PIN_WSTB_LO] == $past(st.port_dir[PIN_WSTB_LO]))
		else $error("lower write strobe drives while disabled");
	a_wstb_hi_width: assert property (i_ext_bus && wstb_en && !i_bus_16bit
		|=> o_pin_oe[PIN_WSTB_HI] == $past(st.port_dir[PIN_WSTB_HI]))
		else $error("upper write strobe drives in 8-bit mode");
	a_hold_req_sync: assert property (s_hold_on
		|-> o_hold_request_in == $past(i_pin[PIN_HOLD_REQ], 2) && !o_pin_oe[PIN_HOLD_REQ])
		else $error("hold request not taken two cycles late");
	a_hold_ack: assert property (i_ext_bus && hold_en
		|=> o_pin_oe[PIN_HOLD_ACK] && o_pin[PIN_HOLD_ACK] == $past(i_hold_ack_out))
		else $error("hold acknowledge not driven");
	a_ready_gate: assert property (!(i_ext_bus && rdy_en) |-> o_ready)
		else $error("ready held low while not in use");
	a_cycle_clk: assert property (i_ext_bus && cke |=> o_pin[PIN_CLK] == $past(i_cycle_clk))
		else $error("machine cycle clock not on its pin");
	a_pulse_gen: assert property (st.pgen_en[0] && !(i_ext_bus && !st.addr_high_output_ctrl[4])
		|=> o_pin_oe[4] && o_pin[4] == $past(i_pulse_gen_out_0_3[0]))
		else $error("pulse output 0 not on its pin");
	a_trig_input: assert property (i_adc_active |=> !o_pin_oe[PIN_P96])
		else $error("trigger pin driven while converter uses it");
	a_port_restore: assert property (s_bus_left
		|=> o_pin_oe[31:24] == $past(st.port_dir[31:24]))
		else $error("port control not restored after bus mode");
	a_read_latency: assert property (i_rd_en && i_addr == OFS_ADDR_HI
		|=> o_rdata == $past(st.addr_high_output_ctrl))
		else $error("register read data wrong or late");
endmodule

// ---- hdl/ebm_pkg.sv ----
package ebm_pkg;
	// register port geometry
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	// shared pins: port 2 [7:0], port 3 [15:8], port 4 [23:16], port 5 [31:24], port 9.6 [32]
	localparam int unsigned NPIN   = 33;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_P2_DATA  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_P3_DATA  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_P4_DATA  = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_P5_DATA  = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_P2_DIR   = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_P3_DIR   = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_P4_DIR   = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_P5_DIR   = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_P96      = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_ADDR_HI  = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_BUS_CTRL = 4'hA;
	localparam logic [ADDR_W-1:0] OFS_PGEN_EN  = 4'hB;

	// fields of the p9.6 register
	localparam int unsigned P96_DATA_BIT = 0;
	localparam int unsigned P96_DIR_BIT  = 1;
	localparam int unsigned P96_PIN_BIT  = 2;

	// fields of bus_pin_ctrl_reg
	localparam int unsigned CTRL_W        = 4;
	localparam int unsigned CTRL_CKE_BIT  = 0;
	localparam int unsigned CTRL_HOLD_BIT = 1;
	localparam int unsigned CTRL_RDY_BIT  = 2;
	localparam int unsigned CTRL_WSTB_BIT = 3;

	// pin indices inside the flat pin vector
	localparam int unsigned PIN_P3_BASE = 8;
	localparam int unsigned PIN_P4_BASE = 16;
	localparam int unsigned PIN_ALE     = 24;
	localparam int unsigned PIN_RD      = 25;
	localparam int unsigned PIN_WSTB_LO  = 26;
	localparam int unsigned PIN_WSTB_HI  = 27;
	localparam int unsigned PIN_HOLD_REQ = 28;
	localparam int unsigned PIN_HOLD_ACK = 29;
	localparam int unsigned PIN_RDY     = 30;
	localparam int unsigned PIN_CLK     = 31;
	localparam int unsigned PIN_P96     = 32;
	localparam int unsigned PGEN_FIRST  = 4;
	localparam int unsigned NPGEN       = 4;

	// reset values
	localparam logic [NPIN-1:0]   RST_PORT_DATA = 33'h0_0000_0000;
	localparam logic [NPIN-1:0]   RST_PORT_DIR  = 33'h0_0000_0000;
	localparam logic [7:0]        RST_ADDR_HI   = 8'h00;
	localparam logic [CTRL_W-1:0] RST_BUS_CTRL  = 4'h0;
	localparam logic [NPGEN-1:0]  RST_PGEN_EN   = 4'h0;

	typedef struct packed {
		logic [NPIN-1:0]   port_data;
		logic [NPIN-1:0]   port_dir;
		logic [7:0]        addr_high_output_ctrl;
		logic [CTRL_W-1:0] bus_pin_ctrl_reg;
		logic [NPGEN-1:0]  pgen_en;
		logic [NPIN-1:0]   sync1;
		logic [NPIN-1:0]   sync2;
		logic [NPIN-1:0]   pin_out;
		logic [NPIN-1:0]   pin_oe;
		logic [DATA_W-1:0] rdata;
	} ebm_state_t;
endpackage

// ---- hdl/ebm_pin_cell.sv ----
`timescale 1ns/1ps
module ebm_pin_cell (
	// function side
	input  wire logic i_func_sel,
	input  wire logic i_func_out,
	input  wire logic i_func_oe,
	// port side
	input  wire logic i_port_data,
	input  wire logic i_port_dir,
	// pin drive
	output logic      o_pin_out,
	output logic      o_pin_oe
);
	// an owning function hides the port's own data and direction completely
	assign o_pin_out = i_func_sel ? i_func_out : i_port_data;
	assign o_pin_oe  = i_func_sel ? i_func_oe  : i_port_dir;
endmodule

// ---- test/ebm_bus_model.sv ----
`timescale 1ns/1ps
module ebm_bus_model (
	// clock
	input  wire logic                     i_clk,
	// device pin drive
	input  wire logic [ebm_pkg::NPIN-1:0] i_pin_out,
	input  wire logic [ebm_pkg::NPIN-1:0] i_pin_oe,
	// far-side levels set by the bench
	input  wire logic                     i_hold_req,
	input  wire logic                     i_ready,
	input  wire logic                     i_trig,
	// resolved pin levels
	output logic      [ebm_pkg::NPIN-1:0] o_pin_level
);
	import ebm_pkg::*;
	logic [NPIN-1:0] ext_drive;
	logic            toggle = 1'b0;
	// released lines change every cycle so a stale value never passes for a driven one
	always_ff @(posedge i_clk) toggle <= ~toggle;
	always_comb begin
		ext_drive = {NPIN{toggle}};
		// two-wire serial pins are outside this mux; software keeps their port released
		ext_drive[PIN_HOLD_REQ] = i_hold_req;
		ext_drive[PIN_RDY] = i_ready;
		ext_drive[PIN_P96] = i_trig;
		o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & ext_drive);
	end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
	import ebm_pkg::*;
	logic              i_clk, i_rst, i_wr_en, i_rd_en, ext, nmx, b16, ale, rd_n, wl_n, wh_n;
	logic              hold_ack_out, cclk, hold_in, rdy, adc, fr, conv, frclk, hreq, prdy, trig;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata, rdata;
	logic [23:0]       baddr;
	logic [3:0]        pgen;
	logic [NPIN-1:0]   lvl, pin_o, pin_oe;
	int                n_mismatch = 0;
	int                n_checks = 0;

	ebm_pin_mux dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(rdata), .i_ext_bus(ext),
		.i_nonmux(nmx), .i_bus_16bit(b16), .i_bus_addr(baddr), .i_ale(ale),
		.i_rd_strobe_n(rd_n), .i_write_strobe_low_n(wl_n), .i_write_strobe_high_n(wh_n),
		.i_hold_ack_out(hold_ack_out), .i_cycle_clk(cclk), .o_hold_request_in(hold_in),
		.o_ready(rdy), .i_pulse_gen_out_0_3(pgen), .i_adc_active(adc),
		.i_freerun_active(fr), .o_converter_trigger_in(conv), .o_freerun_clock_in(frclk),
		.i_pin(lvl), .o_pin(pin_o), .o_pin_oe(pin_oe));
	ebm_bus_model far (.i_clk(i_clk), .i_pin_out(pin_o), .i_pin_oe(pin_oe),
		.i_hold_req(hreq), .i_ready(prdy), .i_trig(trig), .o_pin_level(lvl));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic give_verdict();
		if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_vec(input logic [NPIN-1:0] got, exp, mask);
		n_checks++;
		if ((got & mask) !== (exp & mask)) begin
			n_mismatch++;
			$display("unexpected %0t pins %h exp %h", $time, got & mask, exp & mask);
		end
	endtask

	task automatic chk_rd(input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %0t read %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clk);
		i_wr_en <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_rd_en <= 1'b1;
		addr <= a;
		@(posedge i_clk);
		i_rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic set_bus(input logic e, n, w);
		@(posedge i_clk);
		ext <= e;
		nmx <= n;
		b16 <= w;
	endtask

	task automatic chk_hi(input logic [7:0] p, oe, input logic h, r);
		chk_vec(pin_o, {1'b0, p, 24'h0}, {1'b0, oe, 24'h0});
		chk_vec(pin_oe, {1'b0, oe, 24'h0}, 33'h0_FF00_0000);
		chk_vec({32'h0, hold_in}, {32'h0, h}, 33'h1);
		chk_vec({32'h0, rdy}, {32'h0, r}, 33'h1);
	endtask

	task automatic sc_regs();
		logic [7:0] d;
		for (int a = 4; a < 12; a++) begin
			rd(a[3:0], d);
			chk_rd(d, 8'h00);
		end
		wr(OFS_BUS_CTRL, 8'hFF);
		rd(OFS_BUS_CTRL, d);
		chk_rd(d, 8'h0F);
		wr(4'hC, 8'hFF);
		rd(4'hC, d);
		chk_rd(d, 8'h00);
		wr(OFS_BUS_CTRL, 8'h00);
	endtask

	task automatic sc_addr();
		set_bus(1'b1, 1'b1, 1'b1);
		tick(3);
		chk_vec(pin_o, 33'h0_0096_5AC3, 33'h0_00FF_FFFF);
		chk_vec(pin_oe, 33'h0_00FF_FFFF, 33'h0_00FF_FFFF);
		set_bus(1'b1, 1'b0, 1'b1);
		tick(3);
		chk_vec(pin_oe, 33'h0_0000_00FF, 33'h0_00FF_FFFF);
		chk_vec(pin_o, 33'h0_0000_00C3, 33'h0_0000_00FF);
	endtask

	task automatic sc_upper();
		wr(OFS_P2_DATA, 8'hAA);
		wr(OFS_P2_DIR, 8'hFF);
		wr(OFS_ADDR_HI, 8'hF0);
		tick(3);
		chk_vec(pin_o, 33'hA3, 33'hFF);
		@(posedge i_clk);
		pgen <= 4'h5;
		wr(OFS_PGEN_EN, 8'h0F);
		tick(3);
		chk_vec(pin_o, 33'h53, 33'hFF);
		wr(OFS_ADDR_HI, 8'h00);
		tick(3);
		chk_vec(pin_o, 33'hC3, 33'hFF);
		wr(OFS_P2_DIR, 8'h00);
		set_bus(1'b0, 1'b0, 1'b1);
		tick(3);
		chk_vec(pin_oe, 33'hF0, 33'hFF);
		chk_vec(pin_o, 33'h50, 33'hF0);
		wr(OFS_PGEN_EN, 8'h00);
		tick(3);
		chk_vec(pin_oe, 33'h00, 33'hFF);
	endtask

	task automatic sc_ctrl();
		wr(OFS_P5_DATA, 8'h5A);
		wr(OFS_P5_DIR, 8'hFF);
		set_bus(1'b1, 1'b0, 1'b1);
		ale <= 1'b1;
		rd_n <= 1'b0;
		wl_n <= 1'b0;
		wh_n <= 1'b0;
		hold_ack_out <= 1'b1;
		hreq <= 1'b1;
		prdy <= 1'b0;
		wr(OFS_BUS_CTRL, 8'h0F);
		tick(4);
		chk_hi(8'h21, 8'hAF, 1'b1, 1'b0);
		set_bus(1'b1, 1'b0, 1'b0);
		cclk <= 1'b1;
		hold_ack_out <= 1'b0;
		hreq <= 1'b0;
		prdy <= 1'b1;
		tick(4);
		chk_hi(8'h89, 8'hAF, 1'b0, 1'b1);
		wr(OFS_BUS_CTRL, 8'h00);
		set_bus(1'b1, 1'b0, 1'b1);
		hreq <= 1'b1;
		prdy <= 1'b0;
		tick(4);
		chk_hi(8'h59, 8'hFF, 1'b0, 1'b1);
		set_bus(1'b0, 1'b0, 1'b1);
		tick(3);
		chk_hi(8'h5A, 8'hFF, 1'b0, 1'b1);
	endtask

	task automatic sc_p96();
		logic [7:0] d;
		wr(OFS_P96, 8'h03);
		tick(4);
		chk_vec(pin_o & pin_oe, {1'b1, 32'h0}, {1'b1, 32'h0});
		rd(OFS_P96, d);
		chk_rd(d, 8'h07);
		@(posedge i_clk);
		adc <= 1'b1;
		trig <= 1'b1;
		tick(4);
		chk_vec(pin_oe, 33'h0, {1'b1, 32'h0});
		chk_vec({31'h0, conv, frclk}, 33'h2, 33'h3);
		@(posedge i_clk);
		adc <= 1'b0;
		fr <= 1'b1;
		tick(4);
		chk_vec({31'h0, conv, frclk}, 33'h1, 33'h3);
		@(posedge i_clk);
		fr <= 1'b0;
		tick(3);
		chk_vec(pin_oe, {1'b1, 32'h0}, {1'b1, 32'h0});
	endtask

	initial begin
		{i_wr_en, i_rd_en, ext, nmx, b16, ale, rd_n, wl_n, wh_n} = '0;
		{hold_ack_out, cclk, adc, fr, hreq, prdy, trig, pgen} = '0;
		addr = '0;
		wdata = 8'h00;
		baddr = 24'hC3965A;
		i_rst = 1'b1;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		sc_regs();
		sc_addr();
		sc_upper();
		sc_ctrl();
		sc_p96();
		give_verdict();
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		n_mismatch++;
		$display("unexpected %0t run did not finish", $time);
		give_verdict();
	end
endmodule
